// >>> hw/pcs_defs.svh
`ifndef PCS_DEFS_SVH
`define PCS_DEFS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define PCS_OFS_OPTIONS   8'h86
`define PCS_OFS_POLARITY  8'hAE
`define PCS_OFS_IRQ_CTRL  8'hC0
`define PCS_OFS_CFG_LOW   8'hC2
`define PCS_OFS_CFG_HIGH  8'hC3
`define PCS_OFS_PORT4     8'hD8
`define PCS_OFS_BASE_LO0  8'h84
`define PCS_OFS_BASE_HI0  8'h85
`define PCS_OFS_BASE_LO1  8'h94
`define PCS_OFS_BASE_HI1  8'h95
`define PCS_OFS_BASE_LO2  8'hAC
`define PCS_OFS_BASE_HI2  8'hAD
`define PCS_OFS_BASE_LO3  8'hB4
`define PCS_OFS_BASE_HI3  8'hB5
// ----------------------------------------
// reset values and fields
// ----------------------------------------
`define PCS_RST_PORT      8'hFF
`define PCS_RST_CTRL      8'h00
`define PCS_POL_MASK      8'hF0
`define PCS_POL_LSB       4
`define PCS_PULLUP_BIT    0
`define PCS_IRQ_STRIDE    4
`define PCS_IRQ_TRIG      0
`define PCS_IRQ_PEND      1
`define PCS_IRQ_EN        2
`define PCS_IRQ_PRIO      3
// ----------------------------------------
// comparator masks
// ----------------------------------------
`define PCS_MASK_FULL     16'hFFFF
`define PCS_MASK_PAIR     16'hFFFE
`define PCS_MASK_QUAD     16'hFFFC
`define PCS_MASK_PAGE     16'hFF00
`endif

// >>> hw/pcs_pkg.sv
`default_nettype none
package pcs_pkg;
   typedef enum logic [1:0] {
      PCS_FN_IO   = 2'b00,
      PCS_FN_RD   = 2'b01,
      PCS_FN_WR   = 2'b10,
      PCS_FN_RDWR = 2'b11
   } pcs_func_e;
   typedef enum logic [1:0] {
      PCS_CMP_FULL = 2'b00,
      PCS_CMP_PAIR = 2'b01,
      PCS_CMP_QUAD = 2'b10,
      PCS_CMP_PAGE = 2'b11
   } pcs_cmp_e;
   // one configuration nibble, function in the upper pair
   typedef struct packed {
      pcs_func_e func;
      pcs_cmp_e  cmp;
   } pcs_pin_cfg_s;
   typedef struct packed {
      logic [15:0] addr;
      logic        rd_n;
      logic        wr_n;
   } pcs_xbus_s;
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } pcs_sfr_req_s;
   typedef struct packed {
      logic       wr;
      logic [7:0] addr;
      logic       val;
   } pcs_bit_req_s;
endpackage
`default_nettype wire

// >>> hw/pcs_port4_csio.sv
`include "pcs_defs.svh"
`default_nettype none
//------------------------------------------------------------
// Behaviour
// R01 - two-bit function per pin: io, read, write, read/write strobe
// R02 - io function acts as quasi-bidirectional bit like port 1
// R03 - read strobe asserts only on read with address match
// R04 - write strobe asserts only on write with address match
// R05 - combined strobe asserts on read or write with address match
// R06 - each strobe pin has a 16-bit base, high and low bytes
// R07 - compare 00 matches all sixteen address bits
// R08 - compare 01 matches address bits 15 to 1
// R09 - compare 10 matches address bits 15 to 2
// R10 - compare 11 matches address bits 15 to 8
// R11 - upper config: pin3 function, pin3 compare, pin2 function, pin2 compare
// R12 - lower config: pin1 function, pin1 compare, pin0 function, pin0 compare
// R13 - polarity bits 7..4 for pins 3..0, one means active high
// R14 - settings independent per pin, free mixing of io and strobes
// R15 - port 0 open drain, pull-up option gives pulled-up bidirectional pins
// R16 - trigger bit set selects falling edge, clear selects low level
// R17 - edge mode sets pending on edge, clears when serviced
// R18 - interrupt requested only while its enable bit is set
// R19 - priority bit raises interrupt to high level
// R20 - interrupt control at C0, bit addressable, first enable at C2
// R21 - reset: port data all ones, control registers zero
// R22 - reserved polarity low bits read zero, ignore writes
// R23 - software sets base and polarity before picking a strobe function
//------------------------------------------------------------
module pcs_port4_csio (
   // clock and reset
   input  wire logic                  clock,
   input  wire logic                  rst,
   // special function register access
   input  wire pcs_pkg::pcs_sfr_req_s sfr_req,
   input  wire pcs_pkg::pcs_bit_req_s bit_req,
   output logic [7:0]                 sfr_rdata,
   // external bus strobes
   input  wire pcs_pkg::pcs_xbus_s    xbus,
   // port 4 pins
   input  wire logic [7:0]            p4_in,
   output logic [7:0]                 p4_out,
   output logic [7:0]                 p4_oe,
   // port 0 pins
   input  wire logic [7:0]            p0_latch,
   output logic [7:0]                 p0_out,
   output logic [7:0]                 p0_oe,
   output logic                       port0_pullup_enable,
   // extra interrupts
   input  wire logic                  extra_irq_a_n,
   input  wire logic                  extra_irq_b_n,
   input  wire logic [1:0]            irq_serviced,
   output logic [1:0]                 irq_request,
   output logic [1:0]                 irq_high_priority
);
   localparam int NUM_CS  = 4;
   localparam int NUM_IRQ = 2;
   localparam logic [7:0] BASE_LO_OFS [NUM_CS] = '{
      `PCS_OFS_BASE_LO0, `PCS_OFS_BASE_LO1,
      `PCS_OFS_BASE_LO2, `PCS_OFS_BASE_LO3};
   localparam logic [7:0] BASE_HI_OFS [NUM_CS] = '{
      `PCS_OFS_BASE_HI0, `PCS_OFS_BASE_HI1,
      `PCS_OFS_BASE_HI2, `PCS_OFS_BASE_HI3};

   //------------------------------------------------------------
   // register state
   //------------------------------------------------------------
   logic [7:0]  port4_data;
   logic [7:0]  strobe_polarity;
   logic [7:0]  pin_config_low;
   logic [7:0]  pin_config_high;
   logic [7:0]  port_options;
   logic [7:0]  irq_cfg;
   logic [1:0]  irq_pending;
   logic [7:0]  base_addr_low  [NUM_CS];
   logic [7:0]  base_addr_high [NUM_CS];
   logic [7:0]  extra_irq_control;
   logic [7:0]  wr_val;
   logic [7:0]  rd_mux;
   logic [15:0] cfg_all;
   logic [NUM_CS-1:0] cs_level;
   logic [NUM_CS-1:0] strobe_on;

   //------------------------------------------------------------
   // write decode
   //------------------------------------------------------------
   // byte writes hit any register, bit writes only aligned ones
   function automatic logic [7:0] wr_mask(
      input pcs_pkg::pcs_sfr_req_s s,
      input pcs_pkg::pcs_bit_req_s b,
      input logic [7:0]            ofs,
      input logic                  bitable
   );
      logic [7:0] m;
      m = 8'h00;
      if (s.wr && s.addr == ofs) begin
         m = 8'hFF;
      end else if (bitable && !s.wr && b.wr && b.addr[7:3] == ofs[7:3]) begin
         m = 8'h01 << b.addr[2:0];
      end
      return m;
   endfunction

   function automatic logic [7:0] merge(
      input logic [7:0] old,
      input logic [7:0] val,
      input logic [7:0] m
   );
      return (old & ~m) | (val & m);
   endfunction

   assign wr_val = sfr_req.wr ? sfr_req.wdata : {8{bit_req.val}};

   logic [7:0] m_port4;
   logic [7:0] m_pol;
   logic [7:0] m_low;
   logic [7:0] m_high;
   logic [7:0] m_opt;
   logic [7:0] m_irqctl;

   assign m_port4 = wr_mask(sfr_req, bit_req, `PCS_OFS_PORT4, 1'b1);
   assign m_pol   = wr_mask(sfr_req, bit_req, `PCS_OFS_POLARITY, 1'b0);
   assign m_low   = wr_mask(sfr_req, bit_req, `PCS_OFS_CFG_LOW, 1'b0);
   assign m_high  = wr_mask(sfr_req, bit_req, `PCS_OFS_CFG_HIGH, 1'b0);
   assign m_opt   = wr_mask(sfr_req, bit_req, `PCS_OFS_OPTIONS, 1'b0);
   assign m_irqctl = wr_mask(sfr_req, bit_req, `PCS_OFS_IRQ_CTRL, 1'b1); // R20

   //------------------------------------------------------------
   // byte registers
   //------------------------------------------------------------
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         port4_data <= `PCS_RST_PORT; // R21
      end else begin
         port4_data <= merge(port4_data, wr_val, m_port4);
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         strobe_polarity <= `PCS_RST_CTRL; // R21
         pin_config_low  <= `PCS_RST_CTRL;
         pin_config_high <= `PCS_RST_CTRL;
         port_options    <= `PCS_RST_CTRL;
      end else begin
         // reserved low bits never store
         strobe_polarity <= merge(strobe_polarity, wr_val, m_pol & `PCS_POL_MASK); // R22
         pin_config_low  <= merge(pin_config_low, wr_val, m_low); // R12
         pin_config_high <= merge(pin_config_high, wr_val, m_high); // R11
         port_options    <= merge(port_options, wr_val, m_opt);
      end
   end

   // pending bits live in their own flops below
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         irq_cfg <= `PCS_RST_CTRL; // R21
      end else begin
         irq_cfg <= merge(irq_cfg, wr_val, m_irqctl);
      end
   end

   genvar k;
   generate
      for (k = 0; k < NUM_CS; k++) begin : g_base
         always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
               base_addr_low[k]  <= `PCS_RST_CTRL;
               base_addr_high[k] <= `PCS_RST_CTRL;
            end else begin
               if (sfr_req.wr && sfr_req.addr == BASE_LO_OFS[k]) begin
                  base_addr_low[k] <= sfr_req.wdata; // R06
               end
               if (sfr_req.wr && sfr_req.addr == BASE_HI_OFS[k]) begin
                  base_addr_high[k] <= sfr_req.wdata; // R06
               end
            end
         end
      end
   endgenerate

   //------------------------------------------------------------
   // pin synchronisers
   //------------------------------------------------------------
   logic [7:0] p4_s1;
   logic [7:0] p4_s2;
   logic [1:0] irq_s1;
   logic [1:0] irq_s2;
   logic [1:0] irq_prev;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         p4_s1 <= 8'hFF;
         p4_s2 <= 8'hFF;
      end else begin
         p4_s1 <= p4_in;
         p4_s2 <= p4_s1;
      end
   end

   // idle high so no edge is seen leaving reset
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         irq_s1   <= 2'h3;
         irq_s2   <= 2'h3;
         irq_prev <= 2'h3;
      end else begin
         irq_s1   <= {extra_irq_b_n, extra_irq_a_n};
         irq_s2   <= irq_s1;
         irq_prev <= irq_s2;
      end
   end

   //------------------------------------------------------------
   // chip-select strobes
   //------------------------------------------------------------
   assign cfg_all = {pin_config_high, pin_config_low}; // R11 R12

   genvar i;
   generate
      for (i = 0; i < NUM_CS; i++) begin : g_cs
         // each pin owns its nibble, base and polarity
         pcs_strobe_unit u_strobe ( // R14
            .clock     (clock),
            .rst       (rst),
            .cfg       (cfg_all[4*i +: 4]),
            .polarity  (strobe_polarity[`PCS_POL_LSB + i]), // R13
            .base      ({base_addr_high[i], base_addr_low[i]}),
            .xbus      (xbus),
            .cs_level  (cs_level[i]),
            .strobe_on (strobe_on[i])
         );
         // strobes drive both levels, io only pulls low
         assign p4_out[i] = strobe_on[i] ? cs_level[i] : port4_data[i]; // R01
         assign p4_oe[i]  = strobe_on[i] || !port4_data[i]; // R02
      end
   endgenerate

   // upper half stays plain quasi-bidirectional
   assign p4_out[7:4] = port4_data[7:4];
   assign p4_oe[7:4]  = ~port4_data[7:4]; // R02

   //------------------------------------------------------------
   // port 0
   //------------------------------------------------------------
   // pull-ups come from outside, this end only sinks
   assign port0_pullup_enable = port_options[`PCS_PULLUP_BIT]; // R15
   assign p0_out = 8'h00;
   assign p0_oe  = ~p0_latch; // R15

   //------------------------------------------------------------
   // extra interrupts
   //------------------------------------------------------------
   genvar c;
   generate
      for (c = 0; c < NUM_IRQ; c++) begin : g_irq
         localparam int B = c * `PCS_IRQ_STRIDE;
         logic trig;
         logic fall;
         assign trig = irq_cfg[B + `PCS_IRQ_TRIG];
         assign fall = irq_prev[c] && !irq_s2[c];

         // a detected edge beats a service or software clear
         always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
               irq_pending[c] <= 1'b0;
            end else if (!trig) begin
               irq_pending[c] <= !irq_s2[c]; // R16
            end else if (fall) begin
               irq_pending[c] <= 1'b1; // R16 R17
            end else if (irq_serviced[c]) begin
               irq_pending[c] <= 1'b0; // R17
            end else if (m_irqctl[B + `PCS_IRQ_PEND]) begin
               irq_pending[c] <= wr_val[B + `PCS_IRQ_PEND];
            end
         end

         assign irq_request[c] = irq_cfg[B + `PCS_IRQ_EN] && irq_pending[c]; // R18
         assign irq_high_priority[c] = irq_cfg[B + `PCS_IRQ_PRIO]; // R19

         sequence s_fall;
            $fell(irq_s2[c]) ##0 trig;
         endsequence

         a_edge_pending: assert property (@(posedge clock) disable iff (rst) // R17
            s_fall |=> irq_pending[c]) else $error("edge did not set pending");
         a_service_clear: assert property (@(posedge clock) disable iff (rst) // R17
            (trig && irq_serviced[c] && !fall) |=> !irq_pending[c]) else $error("service did not clear");
         a_level_follow: assert property (@(posedge clock) disable iff (rst) // R16
            !trig |=> irq_pending[c] == !$past(irq_s2[c])) else $error("level pending wrong");
         a_enable_gate: assert property (@(posedge clock) disable iff (rst) // R18
            !irq_cfg[B + `PCS_IRQ_EN] |-> !irq_request[c]) else $error("request while disabled");
      end
   endgenerate

   //------------------------------------------------------------
   // read path
   //------------------------------------------------------------
   always_comb begin
      extra_irq_control = irq_cfg;
      extra_irq_control[`PCS_IRQ_PEND] = irq_pending[0];
      extra_irq_control[`PCS_IRQ_STRIDE + `PCS_IRQ_PEND] = irq_pending[1];
   end

   // unmapped offsets read zero; port 4 reads the pins
   always_comb begin
      rd_mux = 8'h00;
      case (sfr_req.addr)
         `PCS_OFS_PORT4:    rd_mux = p4_s2;
         `PCS_OFS_POLARITY: rd_mux = strobe_polarity & `PCS_POL_MASK; // R22
         `PCS_OFS_CFG_LOW:  rd_mux = pin_config_low;
         `PCS_OFS_CFG_HIGH: rd_mux = pin_config_high;
         `PCS_OFS_OPTIONS:  rd_mux = port_options;
         `PCS_OFS_IRQ_CTRL: rd_mux = extra_irq_control; // R20
         default:           rd_mux = 8'h00;
      endcase
      for (int n = 0; n < NUM_CS; n++) begin
         if (sfr_req.addr == BASE_LO_OFS[n]) begin
            rd_mux = base_addr_low[n];
         end
         if (sfr_req.addr == BASE_HI_OFS[n]) begin
            rd_mux = base_addr_high[n];
         end
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sfr_rdata <= 8'h00;
      end else if (sfr_req.rd) begin
         sfr_rdata <= rd_mux;
      end
   end

   //------------------------------------------------------------
   // checks
   //------------------------------------------------------------
   a_pol_reserved: assert property (@(posedge clock) disable iff (rst) // R22
      (sfr_req.wr && sfr_req.addr == `PCS_OFS_POLARITY) |=> strobe_polarity[3:0] == 4'h0)
      else $error("reserved polarity bits stored");
   a_gpio_drive: assert property (@(posedge clock) disable iff (rst) // R02
      (pin_config_low[3:2] == 2'b00) |-> (p4_oe[0] == !port4_data[0]))
      else $error("gpio pin drive wrong");
   a_extra_irq_control_bit: assert property (@(posedge clock) disable iff (rst) // R20
      (bit_req.wr && !sfr_req.wr && bit_req.addr == 8'hC2) |=> irq_cfg[2] == $past(bit_req.val))
      else $error("bit write to enable lost");
endmodule // pcs_port4_csio
`default_nettype wire

// >>> hw/pcs_strobe_unit.sv
`include "pcs_defs.svh"
`default_nettype none
module pcs_strobe_unit (
   // clock and reset
   input  wire logic                 clock,
   input  wire logic                 rst,
   // settings
   input  wire pcs_pkg::pcs_pin_cfg_s cfg,
   input  wire logic                 polarity,
   input  wire logic [15:0]          base,
   // external bus
   input  wire pcs_pkg::pcs_xbus_s   xbus,
   // pin side
   output logic                      cs_level,
   output logic                      strobe_on
);
   logic [15:0] mask;
   logic        hit;
   logic        want;
   logic        active;

   always_comb begin
      case (cfg.cmp)
         pcs_pkg::PCS_CMP_FULL: mask = `PCS_MASK_FULL; // R07
         pcs_pkg::PCS_CMP_PAIR: mask = `PCS_MASK_PAIR; // R08
         pcs_pkg::PCS_CMP_QUAD: mask = `PCS_MASK_QUAD; // R09
         default:               mask = `PCS_MASK_PAGE; // R10
      endcase
   end

   assign hit = ((xbus.addr ^ base) & mask) == 16'h0000; // R06

   always_comb begin
      case (cfg.func)
         pcs_pkg::PCS_FN_RD:   want = !xbus.rd_n; // R03
         pcs_pkg::PCS_FN_WR:   want = !xbus.wr_n; // R04
         pcs_pkg::PCS_FN_RDWR: want = !xbus.rd_n || !xbus.wr_n; // R05
         default:              want = 1'b0;
      endcase
   end

   assign active    = hit && want;
   assign strobe_on = cfg.func != pcs_pkg::PCS_FN_IO; // R01

   // idle level is the inverse of the polarity bit
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cs_level <= 1'b1;
      end else begin
         cs_level <= active ? polarity : !polarity; // R13
      end
   end

   sequence s_rd_hit;
      cfg.func == pcs_pkg::PCS_FN_RD && !xbus.rd_n && hit;
   endsequence
   sequence s_wr_hit;
      cfg.func == pcs_pkg::PCS_FN_WR && !xbus.wr_n && hit;
   endsequence

   a_read_strobe: assert property (@(posedge clock) disable iff (rst) // R03
      s_rd_hit |=> cs_level == $past(polarity)) else $error("read strobe missing");
   a_write_strobe: assert property (@(posedge clock) disable iff (rst) // R04
      s_wr_hit |=> cs_level == $past(polarity)) else $error("write strobe missing");
   a_combined_strobe: assert property (@(posedge clock) disable iff (rst) // R05
      (cfg.func == pcs_pkg::PCS_FN_RDWR && hit && (!xbus.rd_n || !xbus.wr_n))
      |=> cs_level == $past(polarity)) else $error("combined strobe missing");
   a_idle_level: assert property (@(posedge clock) disable iff (rst) // R13
      (!hit || xbus.rd_n && xbus.wr_n) |=> cs_level != $past(polarity)) else $error("strobe not idle");
   a_cmp_full: assert property (@(posedge clock) disable iff (rst) // R07
      cfg.cmp == pcs_pkg::PCS_CMP_FULL |-> hit == (xbus.addr == base)) else $error("full compare wrong");
   a_cmp_pair: assert property (@(posedge clock) disable iff (rst) // R08
      cfg.cmp == pcs_pkg::PCS_CMP_PAIR |-> hit == (xbus.addr[15:1] == base[15:1])) else $error("pair compare wrong");
   a_cmp_quad: assert property (@(posedge clock) disable iff (rst) // R09
      cfg.cmp == pcs_pkg::PCS_CMP_QUAD |-> hit == (xbus.addr[15:2] == base[15:2])) else $error("quad compare wrong");
   a_cmp_page: assert property (@(posedge clock) disable iff (rst) // R10
      cfg.cmp == pcs_pkg::PCS_CMP_PAGE |-> hit == (xbus.addr[15:8] == base[15:8])) else $error("page compare wrong");
endmodule // pcs_strobe_unit
`default_nettype wire

// >>> test/pcs_periph_model.sv
`default_nettype none
module pcs_periph_model (
   // clock
   input  wire logic       clock,
   // drive from the block
   input  wire logic [7:0] p4_out,
   input  wire logic [7:0] p4_oe,
   input  wire logic [7:0] p0_out,
   input  wire logic [7:0] p0_oe,
   input  wire logic       pullup_on,
   // resolved pins
   output logic [7:0]      p4_pins,
   output logic [7:0]      p0_pins
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] wobble = 8'h00;
   // a floating line must not look like a steady level
   always @(posedge clock) wobble <= ~wobble;
   // board pull-ups on port 4 pins
   assign p4_pins = (p4_oe & p4_out) | ~p4_oe;
   assign p0_pins = (p0_oe & p0_out) | (~p0_oe & (pullup_on ? 8'hFF : wobble));
endmodule // pcs_periph_model
`default_nettype wire

// >>> test/pcs_port4_csio_test.sv
`include "pcs_defs.svh"
`default_nettype none
module pcs_port4_csio_test;
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic                  clock = 1'b0;
   logic                  rst = 1'b1;
   pcs_pkg::pcs_sfr_req_s sfr_req = '0;
   pcs_pkg::pcs_bit_req_s bit_req = '0;
   pcs_pkg::pcs_xbus_s    xbus = '{16'h0000, 1'b1, 1'b1};
   logic [7:0]            sfr_rdata, p4_out, p4_oe, p4_pins, p0_out, p0_oe, p0_pins;
   logic [7:0]            p0_latch = 8'hFF;
   logic                  p0_pullup;
   logic                  extra_irq_a_n = 1'b1;
   logic                  extra_irq_b_n = 1'b1;
   logic [1:0]            irq_serviced = 2'b00;
   logic [1:0]            irq_request, irq_high_priority;
   logic [2:0]            probe = 3'd0;
   logic                  rd_d = 1'b0;
   logic [10:0]           exp_q[$];
   int                    error_cnt = 0;
   int                    total_checks = 0;
   int                    seed = 32'h1393;
   localparam logic [7:0]  RST_OFS [8] = '{`PCS_OFS_OPTIONS, `PCS_OFS_POLARITY, `PCS_OFS_IRQ_CTRL,
      `PCS_OFS_CFG_LOW, `PCS_OFS_CFG_HIGH, `PCS_OFS_BASE_LO0, `PCS_OFS_BASE_HI3, 8'h87};
   localparam logic [7:0]  BASE_LO [4] = '{`PCS_OFS_BASE_LO0, `PCS_OFS_BASE_LO1,
      `PCS_OFS_BASE_LO2, `PCS_OFS_BASE_LO3};
   localparam logic [15:0] MASKS [4] = '{16'hFFFF, 16'hFFFE, 16'hFFFC, 16'hFF00};
   always #5 clock = ~clock;
   pcs_port4_csio uut (.clock(clock), .rst(rst), .sfr_req(sfr_req), .bit_req(bit_req),
      .sfr_rdata(sfr_rdata), .xbus(xbus), .p4_in(p4_pins), .p4_out(p4_out), .p4_oe(p4_oe),
      .p0_latch(p0_latch), .p0_out(p0_out), .p0_oe(p0_oe), .port0_pullup_enable(p0_pullup),
      .extra_irq_a_n(extra_irq_a_n), .extra_irq_b_n(extra_irq_b_n), .irq_serviced(irq_serviced),
      .irq_request(irq_request), .irq_high_priority(irq_high_priority));
   pcs_periph_model peer (.clock(clock), .p4_out(p4_out), .p4_oe(p4_oe), .p0_out(p0_out),
      .p0_oe(p0_oe), .pullup_on(p0_pullup), .p4_pins(p4_pins), .p0_pins(p0_pins));
   // ----------------------------------------
   // checking
   // ----------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic test_done();
      if (error_cnt == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // read data lands one cycle after the read edge
   always @(posedge clock) begin
      rd_d <= sfr_req.rd;
      if ((rd_d || probe != 3'd0) && exp_q.size() > 0) begin
         case (exp_q[0][10:8])
            3'd0: check(sfr_rdata, exp_q[0][7:0]);
            3'd1: check(p4_out, exp_q[0][7:0]);
            3'd2: check(p4_oe, exp_q[0][7:0]);
            3'd3: begin
               check(p0_oe, exp_q[0][7:0]);
               check(p0_out, 8'h00);
               // pulled-up lines read back the latch
               check(p0_pins, ~exp_q[0][7:0]);
            end
            default: check({3'b000, p0_pullup, irq_high_priority, irq_request}, exp_q[0][7:0]);
         endcase
         void'(exp_q.pop_front());
      end
   end
   // ----------------------------------------
   // drivers
   // ----------------------------------------
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clock) sfr_req = '{1'b1, 1'b0, a, d};
      @(negedge clock) sfr_req = '0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge clock) sfr_req = '{1'b0, 1'b1, a, 8'h00};
      exp_q.push_back({3'd0, e});
      @(negedge clock) sfr_req = '0;
   endtask
   task automatic look(input logic [2:0] k, input logic [7:0] e);
      @(negedge clock) probe = k;
      exp_q.push_back({k, e});
      @(negedge clock) probe = 3'd0;
   endtask
   task automatic setbit(input logic [7:0] a);
      @(negedge clock) bit_req = '{1'b1, a, 1'b1};
      @(negedge clock) bit_req = '0;
   endtask
   task automatic pulse_pin(input logic b);
      @(negedge clock) if (b) extra_irq_b_n = 1'b0; else extra_irq_a_n = 1'b0;
      repeat (4) @(negedge clock);
      if (b) extra_irq_b_n = 1'b1; else extra_irq_a_n = 1'b1;
   endtask
   task automatic strobe(input int p, input logic [1:0] f, input logic [1:0] c, input logic hit);
      logic [15:0] base, addr;
      logic        pol, rdc, on;
      logic [7:0]  e;
      base = 16'($random(seed));
      pol = 1'($random(seed));
      rdc = 1'($random(seed));
      addr = ((hit ? base : base ^ 16'h8000) & MASKS[c]) | (16'($random(seed)) & ~MASKS[c]);
      on = hit && (f == 2'b11 || (f == 2'b01 && rdc) || (f == 2'b10 && !rdc));
      // the other pair may still hold a strobe from an earlier pin
      wr(p < 2 ? `PCS_OFS_CFG_HIGH : `PCS_OFS_CFG_LOW, 8'h00);
      wr(p < 2 ? `PCS_OFS_CFG_LOW : `PCS_OFS_CFG_HIGH, 8'h00);
      wr(BASE_LO[p], base[7:0]);
      wr(BASE_LO[p] + 8'h01, base[15:8]);
      wr(`PCS_OFS_POLARITY, {8{pol}} & (8'h10 << p));
      wr(p < 2 ? `PCS_OFS_CFG_LOW : `PCS_OFS_CFG_HIGH, {4'h0, f, c} << (4 * (p % 2)));
      @(negedge clock) xbus = '{addr, ~rdc, rdc};
      e = 8'hFF;
      e[p] = (f == 2'b00) ? 1'b1 : ~(pol ^ on);
      look(3'd1, e);
      xbus = '{addr, 1'b1, 1'b1};
      e[p] = (f == 2'b00) ? 1'b1 : ~pol;
      look(3'd1, e);
      look(3'd2, (f == 2'b00) ? 8'h00 : 8'h01 << p);
   endtask
   // ----------------------------------------
   // sequence
   // ----------------------------------------
   initial begin
      repeat (4) @(posedge clock);
      @(negedge clock) rst = 1'b0;
      foreach (RST_OFS[i]) rd(RST_OFS[i], 8'h00);
      rd(`PCS_OFS_PORT4, 8'hFF);
      wr(`PCS_OFS_POLARITY, 8'hFF);
      rd(`PCS_OFS_POLARITY, 8'hF0);
      for (int p = 0; p < 4; p++) begin
         for (int f = 0; f < 4; f++) begin
            for (int c = 0; c < 8; c++) strobe(p, 2'(f), 2'(c), 1'(c / 4));
         end
      end
      wr(`PCS_OFS_CFG_LOW, 8'h00);
      wr(`PCS_OFS_CFG_HIGH, 8'h00);
      wr(`PCS_OFS_PORT4, 8'hA5);
      look(3'd1, 8'hA5);
      look(3'd2, 8'h5A);
      rd(`PCS_OFS_PORT4, 8'hA5);
      wr(`PCS_OFS_OPTIONS, 8'h01);
      @(negedge clock) p0_latch = 8'($random(seed));
      look(3'd3, ~p0_latch);
      look(3'd4, 8'h10);
      wr(`PCS_OFS_IRQ_CTRL, 8'h55);
      pulse_pin(1'b0);
      look(3'd4, 8'h11);
      @(negedge clock) irq_serviced = 2'b01;
      @(negedge clock) irq_serviced = 2'b00;
      look(3'd4, 8'h10);
      wr(`PCS_OFS_IRQ_CTRL, 8'h45);
      @(negedge clock) extra_irq_b_n = 1'b0;
      repeat (4) @(negedge clock);
      look(3'd4, 8'h12);
      extra_irq_b_n = 1'b1;
      repeat (4) @(negedge clock);
      look(3'd4, 8'h10);
      wr(`PCS_OFS_IRQ_CTRL, 8'h01);
      pulse_pin(1'b0);
      look(3'd4, 8'h10);
      rd(`PCS_OFS_IRQ_CTRL, 8'h03);
      setbit(8'hC2);
      setbit(8'hC3);
      setbit(8'hC7);
      look(3'd4, 8'h1D);
      rd(`PCS_OFS_IRQ_CTRL, 8'h8F);
      for (int i = 0; i < 20 && exp_q.size() > 0; i++) @(negedge clock);
      if (exp_q.size() > 0) error_cnt++;
      test_done();
   end
endmodule // pcs_port4_csio_test
`default_nettype wire
